// ==== rtl/upm_consts.vh ====
`ifndef UPM_CONSTS_VH
`define UPM_CONSTS_VH
// Register byte offsets on the 5-bit address
`define UPM_OFF_DATA   5'h00
`define UPM_OFF_IEN    5'h04
`define UPM_OFF_IID    5'h08
`define UPM_OFF_LCTL   5'h0C
`define UPM_OFF_MCTL   5'h10
`define UPM_OFF_LSTAT  5'h14
`define UPM_OFF_MSTAT  5'h18
`define UPM_OFF_SCR    5'h1C
// Line control fields
`define UPM_LC_DLAB    7
`define UPM_LC_BRK     6
// Modem control fields
`define UPM_MC_DTR     0
`define UPM_MC_RTS     1
`define UPM_MC_OUT1    2
`define UPM_MC_OUT2    3
`define UPM_MC_SIR     6
// FIFO control fields
`define UPM_FC_EN      0
`define UPM_FC_RXRST   1
`define UPM_FC_TXRST   2
`define UPM_FC_DMA     3
// Interrupt enable fields
`define UPM_IE_RDA     0
`define UPM_IE_THRE    1
`define UPM_IE_RLS     2
`define UPM_IE_MS      3
// Interrupt identity codes
`define UPM_ID_NONE    4'h1
`define UPM_ID_RLS     4'h6
`define UPM_ID_RDA     4'h4
`define UPM_ID_CTO     4'hC
`define UPM_ID_THRE    4'h2
`define UPM_ID_MS      4'h0
`define UPM_ID_BUSY    4'h7
// Reset values and timing counts
`define UPM_LSTAT_RST  8'h60
`define UPM_ZERO8      8'h00
`define UPM_TO_TICKS   10'h280
`define UPM_PH_LAST    4'hF
`define UPM_PH_MID     4'h7
`define UPM_SIR_PH     4'h3
`define UPM_FRAME_LAST 4'h9
`define UPM_DATA_LAST  3'h7
`endif

// ==== rtl/upm_top.v ====
// Notes on behaviour
// - Receive FIFO RAM port: 10-bit data, registered pointers, low enables, registered chip enable.
// - Modem inputs are active low and registered on the bus clock.
// - Modem control outputs are registered active-low levels from control bits.
// - DMA signals active low by default; active high when polarity option is no.
// - Transmit DMA request is registered, raised when the transmit buffer needs service.
// - With extra DMA signals, transmit single shows a free transmit entry.
// - Receive DMA request is registered, raised when the receive buffer needs service.
// - With extra DMA signals, receive single shows at least one received entry.
// - Transmit acknowledge from the DMA controller is taken unregistered.
// - Receive acknowledge arrives once the DMA controller has taken its data.
// - Without extra DMA signals, registered active-low legacy service outputs exist.
// - Serial input and output are active high and registered on the clock.
// - Infrared input registered active high, infrared output registered active low.
// - One registered active-high interrupt line on the bus clock.
// - Diag bus: zero above bit 13, push, pop, triggers, DMA mode, FIFO enable.
// - Diag bits 6 to 1 show each enabled interrupt source in priority order.
// - Bus-domain sleep request is registered and high while the UART is inactive.
// - Serial-domain sleep request only in two-clock builds; none exists here.
// - Registers decode from a 5-bit address on word boundaries; low bits ignored.
// - Offset 0x00 is receive buffer or transmit holding, or divisor low when latched.
// - Offset 0x04 is divisor high or interrupt enable; both reset to zero.
// - External receive RAM port always exists and holds receive data with FIFOs enabled or disabled.
`timescale 1ns/10ps
`include "upm_consts.vh"

// Transmit FIFO; drain stalls while a character is sent
module upm_fifo #(
    parameter W  = 8,
    parameter AW = 5
) (
    // Clock and reset
    input  wire          i_ref_clk,
    input  wire          i_srst,
    input  wire          i_flush,
    // Fill side
    input  wire          i_wr_valid,
    output wire          o_wr_ready,
    input  wire [W-1:0]  i_wr_data,
    // Drain side
    output wire          o_rd_valid,
    input  wire          i_rd_ready,
    output wire [W-1:0]  o_rd_data,
    output wire [AW:0]   o_level
);
    reg  [W-1:0] mem [0:(1<<AW)-1];
    reg  [AW:0]  wp_q;
    reg  [AW:0]  rp_q;
    wire         push = i_wr_valid & o_wr_ready;
    wire         pop  = o_rd_valid & i_rd_ready;

    assign o_level    = wp_q - rp_q;
    assign o_wr_ready = (o_level[AW] == 1'b0);
    assign o_rd_valid = (wp_q != rp_q);
    assign o_rd_data  = mem[rp_q[AW-1:0]];

    // Pointers carry one wrap bit so full and empty are distinct
    always @(posedge i_ref_clk) begin
        if (i_srst | i_flush) begin
            wp_q <= {(AW+1){1'b0}};
            rp_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wp_q[AW-1:0]] <= i_wr_data;
                wp_q              <= wp_q + 1'b1;
            end
            if (pop)
                rp_q <= rp_q + 1'b1;
        end
    end
endmodule // upm_fifo

module upm_top #(
    parameter DMA_POLARITY_OPT_OPT   = 1,
    parameter EXTRA_DMA_SIGNALS_OPT_OPT = 1,
    parameter SIR_EN        = 1,
    parameter CLK_GATE_EN   = 1,
    parameter TXF_AW        = 5,
    parameter RXF_AW        = 5
) (
    // Clock and reset
    input  wire              i_ref_clk,
    input  wire              i_srst,
    input  wire              i_scan_mode,
    // Register port
    input  wire              i_psel,
    input  wire              i_penable,
    input  wire              i_pwrite,
    input  wire [4:0]        i_paddr,
    input  wire [31:0]       i_pwdata,
    output reg  [31:0]       o_prdata,
    // External receive FIFO RAM
    input  wire [9:0]        i_rx_ram_out,
    output wire [9:0]        o_rx_ram_in,
    output reg  [RXF_AW-1:0] o_rx_ram_rd_addr,
    output reg  [RXF_AW-1:0] o_rx_ram_wr_addr,
    output wire              o_rx_ram_we_n,
    output wire              o_rx_ram_re_n,
    output reg               o_rx_ram_rd_ce_n,
    // Modem lines
    input  wire              i_clear_to_send_in_n,
    input  wire              i_set_ready_in_n,
    input  wire              i_carrier_detect_in_n,
    input  wire              i_ring_indicate_in_n,
    output reg               o_terminal_ready_out_n,
    output reg               o_request_send_out_n,
    output reg               o_user_out_two_n,
    output reg               o_user_out_one_n,
    // DMA handshake, level set by DMA_POLARITY_OPT_OPT; legacy service outputs always active low
    output reg               o_dma_tx_req,
    output reg               o_dma_tx_single,
    input  wire              i_dma_tx_ack,
    output reg               o_dma_rx_req,
    output reg               o_dma_rx_single,
    input  wire              i_dma_rx_ack,
    output reg               o_legacy_tx_service_n,
    output reg               o_legacy_rx_service_n,
    // Serial and infrared lines
    input  wire              i_serial_input,
    output reg               o_serial_output,
    input  wire              i_sir_in,
    output reg               o_sir_out_n,
    // Interrupt, debug, clock control
    output reg               o_interrupt_line,
    output wire [31:0]       o_diag_bus,
    output reg               o_bus_domain_sleep_request
);
    localparam TX_IDLE = 1'b0;
    localparam TX_SEND = 1'b1;
    localparam RX_IDLE = 2'b00;
    localparam RX_STRT = 2'b01;
    localparam RX_DATA = 2'b10;
    localparam RX_STOP = 2'b11;
    localparam ACT     = (DMA_POLARITY_OPT_OPT != 0) ? 1'b0 : 1'b1;

    reg  [7:0]  dll_q, dlh_q, ien_q, lctl_q, mctl_q, fctl_q, scr_q;
    reg  [3:0]  msync1_q, msync2_q, mprev_q, mdelta_q;
    reg         oe_q, fe_q, bi_q, busy_det_q;
    reg  [15:0] bcnt_q;
    reg         sin_q, sir_q, txst_q, tx_pop_q, rx_push_q;
    reg  [3:0]  txph_q, txbit_q, rxph_q, sirh_q;
    reg  [9:0]  txsh_q, to_q;
    reg  [1:0]  rxst_q;
    reg  [2:0]  rxbit_q;
    reg  [7:0]  rxsh_q;
    reg  [RXF_AW:0] rxwp_q, rxrp_q;
    reg         txhold_q, rxhold_q;
    reg  [9:0]  rxword_q;

    // Bus phases: reads sample in setup, writes and side effects in access
    wire        acc    = i_psel & i_penable;
    wire        wr     = acc & i_pwrite;
    wire        rd     = acc & ~i_pwrite;
    wire [4:0]  off    = {i_paddr[4:2], 2'b00};
    wire        dlab   = lctl_q[`UPM_LC_DLAB];
    wire        fen    = fctl_q[`UPM_FC_EN];
    wire        sirm   = (SIR_EN != 0) & mctl_q[`UPM_MC_SIR];
    wire        tick   = (bcnt_q == 16'h0001);
    wire [15:0] div    = {dlh_q, dll_q};

    // Transmit FIFO; writes to a full FIFO are dropped
    wire        txf_rdy, txf_vld;
    wire [7:0]  txf_dat;
    wire [TXF_AW:0] txf_lvl;
    wire        txf_full = fen ? ~txf_rdy : (txf_lvl != {(TXF_AW+1){1'b0}});
    wire        thr_wr   = wr & (off == `UPM_OFF_DATA) & ~dlab & ~txf_full;
    wire        tx_take  = (txst_q == TX_IDLE) & txf_vld & (div != 16'h0000);
    wire        txrst    = wr & (off == `UPM_OFF_IID) & i_pwdata[`UPM_FC_TXRST];
    upm_fifo #(.W(8), .AW(TXF_AW)) u_txf (
        .i_ref_clk  (i_ref_clk),
        .i_srst     (i_srst),
        .i_flush    (txrst),
        .i_wr_valid (thr_wr),
        .o_wr_ready (txf_rdy),
        .i_wr_data  (i_pwdata[7:0]),
        .o_rd_valid (txf_vld),
        .i_rd_ready (tx_take),
        .o_rd_data  (txf_dat),
        .o_level    (txf_lvl)
    );

    // Receive FIFO lives in external RAM; only pointers are kept here
    wire [RXF_AW:0] rxlvl = rxwp_q - rxrp_q;
    wire        rx_empty  = (rxlvl == {(RXF_AW+1){1'b0}});
    wire        rx_full   = fen ? rxlvl[RXF_AW] : ~rx_empty;
    wire        rx_done   = (rxst_q == RX_STOP) & tick & (rxph_q == `UPM_PH_LAST);
    wire        rx_push   = rx_done & ~rx_full;
    wire        rx_pop    = rd & (off == `UPM_OFF_DATA) & ~dlab & ~rx_empty;
    wire        rxrst     = wr & (off == `UPM_OFF_IID) & i_pwdata[`UPM_FC_RXRST];
    wire        rxline    = sirm ? (sirh_q == 4'h0) : sin_q;
    assign o_rx_ram_in    = rxword_q;
    assign o_rx_ram_we_n  = ~rx_push;
    assign o_rx_ram_re_n  = rx_empty;

    // Interrupt sources in priority order
    wire [1:0]  rtrig  = fctl_q[7:6];
    wire [31:0] rthr = (rtrig == 2'b00) ? 1 : (rtrig == 2'b01) ? (1 << (RXF_AW-2)) :
                       (rtrig == 2'b10) ? (1 << (RXF_AW-1)) : (1 << RXF_AW) - 2;
    wire        s_rls  = oe_q | fe_q | bi_q;
    wire        s_rda  = fen ? (rxlvl >= rthr[RXF_AW:0]) : ~rx_empty;
    wire        s_cto  = fen & ~rx_empty & (to_q >= `UPM_TO_TICKS);
    wire        s_thre = ~txf_vld;
    wire        s_ms   = |mdelta_q;
    wire [5:0]  src    = {s_rls, s_rda, s_cto, s_thre, s_ms, busy_det_q};
    wire [5:0]  en     = {ien_q[`UPM_IE_RLS], ien_q[`UPM_IE_RDA], ien_q[`UPM_IE_RDA],
                          ien_q[`UPM_IE_THRE], ien_q[`UPM_IE_MS], 1'b1};
    wire [5:0]  act    = src & en;
    wire [3:0]  iid    = act[5] ? `UPM_ID_RLS : act[4] ? `UPM_ID_RDA :
                         act[3] ? `UPM_ID_CTO : act[2] ? `UPM_ID_THRE :
                         act[1] ? `UPM_ID_MS : act[0] ? `UPM_ID_BUSY : `UPM_ID_NONE;
    wire        tx_idle = (txst_q == TX_IDLE);
    wire [7:0]  lstat  = {1'b0, s_thre & tx_idle, s_thre, bi_q, fe_q, 1'b0, oe_q, ~rx_empty};

    // Diagnostic view is combinational; only the push and pop bits are registered and lag one cycle
    assign o_diag_bus = {18'h00000, rx_push_q, tx_pop_q, fctl_q[7:6], fctl_q[5:4],
                         fctl_q[`UPM_FC_DMA], act, fen};

    // Read data sampled in the setup phase; unmapped offsets read zero
    reg [7:0] rdv;
    always @* begin
        case (off)
            `UPM_OFF_DATA:  rdv = dlab ? dll_q : i_rx_ram_out[7:0];
            `UPM_OFF_IEN:   rdv = dlab ? dlh_q : ien_q;
            `UPM_OFF_IID:   rdv = {fen, fen, 2'b00, iid};
            `UPM_OFF_LCTL:  rdv = lctl_q;
            `UPM_OFF_MCTL:  rdv = mctl_q;
            `UPM_OFF_LSTAT: rdv = lstat;
            `UPM_OFF_MSTAT: rdv = {~msync2_q, mdelta_q};
            `UPM_OFF_SCR:   rdv = scr_q;
            default:        rdv = `UPM_ZERO8;
        endcase
    end

    // Register file and modem outputs
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            dll_q    <= `UPM_ZERO8;
            dlh_q    <= `UPM_ZERO8;
            ien_q    <= `UPM_ZERO8;
            lctl_q   <= `UPM_ZERO8;
            mctl_q   <= `UPM_ZERO8;
            fctl_q   <= `UPM_ZERO8;
            scr_q    <= `UPM_ZERO8;
            o_prdata <= 32'h00000000;
            o_terminal_ready_out_n <= 1'b1;
            o_request_send_out_n   <= 1'b1;
            o_user_out_two_n       <= 1'b1;
            o_user_out_one_n       <= 1'b1;
        end else begin
            if (i_psel & ~i_penable & ~i_pwrite)
                o_prdata <= {24'h000000, rdv};
            if (wr) begin
                case (off)
                    `UPM_OFF_DATA:  if (dlab) dll_q <= i_pwdata[7:0];
                    `UPM_OFF_IEN:   if (dlab) dlh_q <= i_pwdata[7:0];
                                    else ien_q <= i_pwdata[7:0];
                    `UPM_OFF_IID:   fctl_q <= {i_pwdata[7:3], 2'b00, i_pwdata[0]};
                    `UPM_OFF_LCTL:  lctl_q <= i_pwdata[7:0];
                    `UPM_OFF_MCTL:  mctl_q <= i_pwdata[7:0];
                    `UPM_OFF_SCR:   scr_q  <= i_pwdata[7:0];
                    default:        scr_q  <= scr_q;
                endcase
            end
            // Inverted control bits, one flop deep
            o_terminal_ready_out_n <= ~mctl_q[`UPM_MC_DTR];
            o_request_send_out_n   <= ~mctl_q[`UPM_MC_RTS];
            o_user_out_two_n       <= ~mctl_q[`UPM_MC_OUT2];
            o_user_out_one_n       <= ~mctl_q[`UPM_MC_OUT1];
        end
    end

    // Modem inputs: two stages, then edge deltas; a new edge beats the read clear
    wire [3:0] mraw = {i_carrier_detect_in_n, i_ring_indicate_in_n,
                       i_set_ready_in_n, i_clear_to_send_in_n};
    wire       ms_rd = rd & (off == `UPM_OFF_MSTAT);
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            msync1_q <= 4'hF;
            msync2_q <= 4'hF;
            mprev_q  <= 4'hF;
            mdelta_q <= 4'h0;
        end else begin
            msync1_q <= mraw;
            msync2_q <= msync1_q;
            mprev_q  <= msync2_q;
            mdelta_q <= (ms_rd ? 4'h0 : mdelta_q) | (msync2_q ^ mprev_q);
        end
    end

    // Line errors: read of line status clears, new error wins
    wire ls_rd = rd & (off == `UPM_OFF_LSTAT);
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            oe_q       <= 1'b0;
            fe_q       <= 1'b0;
            bi_q       <= 1'b0;
            busy_det_q <= 1'b0;
        end else begin
            oe_q <= (oe_q & ~ls_rd) | (rx_done & rx_full);
            fe_q <= (fe_q & ~ls_rd) | rx_push & rxword_q[8];
            bi_q <= (bi_q & ~ls_rd) | rx_push & rxword_q[9];
            busy_det_q <= (busy_det_q & ~(rd & (off == `UPM_OFF_LCTL)))
                        | (wr & (off == `UPM_OFF_LCTL) & ~tx_idle);
        end
    end

    // 16x baud tick; a zero divisor stops all serial activity
    always @(posedge i_ref_clk) begin
        if (i_srst)
            bcnt_q <= 16'h0000;
        else if (div == 16'h0000)
            bcnt_q <= 16'h0000;
        else if (bcnt_q <= 16'h0001 || bcnt_q > div)
            bcnt_q <= div;
        else
            bcnt_q <= bcnt_q - 16'h0001;
    end

    // Transmitter: start, eight data bits, one stop
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            txst_q   <= TX_IDLE;
            txsh_q   <= 10'h3FF;
            txph_q   <= 4'h0;
            txbit_q  <= 4'h0;
            tx_pop_q <= 1'b0;
        end else begin
            tx_pop_q <= tx_take;
            case (txst_q)
                TX_IDLE: if (tx_take) begin
                    txst_q  <= TX_SEND;
                    txsh_q  <= {1'b1, txf_dat, 1'b0};
                    txph_q  <= 4'h0;
                    txbit_q <= 4'h0;
                end
                TX_SEND: if (tick) begin
                    txph_q <= txph_q + 4'h1;
                    if (txph_q == `UPM_PH_LAST) begin
                        txsh_q  <= {1'b1, txsh_q[9:1]};
                        txbit_q <= txbit_q + 4'h1;
                        if (txbit_q == `UPM_FRAME_LAST)
                            txst_q <= TX_IDLE;
                    end
                end
                default: txst_q <= TX_IDLE;
            endcase
        end
    end

    // Serial and infrared pins; infrared pulses last 3 of 16 phases
    wire txbit = lctl_q[`UPM_LC_BRK] ? 1'b0 : (tx_idle ? 1'b1 : txsh_q[0]);
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            sin_q           <= 1'b1;
            sir_q           <= 1'b0;
            sirh_q          <= 4'h0;
            o_serial_output <= 1'b1;
            o_sir_out_n     <= 1'b1;
        end else begin
            sin_q           <= i_serial_input;
            sir_q           <= (SIR_EN != 0) & i_sir_in;
            o_serial_output <= sirm ? 1'b1 : txbit;
            o_sir_out_n     <= ~(sirm & ~txbit & (txph_q < `UPM_SIR_PH));
            // Stretch a short infrared pulse over one bit time
            if (sir_q)
                sirh_q <= `UPM_PH_LAST;
            else if (tick & (sirh_q != 4'h0))
                sirh_q <= sirh_q - 4'h1;
        end
    end

    // Receiver: mid-start check, sample each data bit at phase 15, the stop bit at phase 14
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            rxst_q   <= RX_IDLE;
            rxph_q   <= 4'h0;
            rxbit_q  <= 3'h0;
            rxsh_q   <= `UPM_ZERO8;
            rxword_q <= 10'h000;
        end else begin
            case (rxst_q)
                RX_IDLE: if (~rxline & (div != 16'h0000)) begin
                    rxst_q <= RX_STRT;
                    rxph_q <= 4'h0;
                end
                RX_STRT: if (tick) begin
                    rxph_q <= rxph_q + 4'h1;
                    if (rxph_q == `UPM_PH_MID) begin
                        rxst_q  <= rxline ? RX_IDLE : RX_DATA;
                        rxph_q  <= 4'h0;
                        rxbit_q <= 3'h0;
                    end
                end
                RX_DATA: if (tick) begin
                    rxph_q <= rxph_q + 4'h1;
                    if (rxph_q == `UPM_PH_LAST) begin
                        rxsh_q  <= {rxline, rxsh_q[7:1]};
                        rxbit_q <= rxbit_q + 3'h1;
                        if (rxbit_q == `UPM_DATA_LAST)
                            rxst_q <= RX_STOP;
                    end
                end
                RX_STOP: if (tick) begin
                    rxph_q <= rxph_q + 4'h1;
                    if (rxph_q == `UPM_PH_LAST)
                        rxst_q <= RX_IDLE;
                    if (rxph_q == `UPM_PH_LAST - 4'h1)
                        rxword_q <= {~rxline & (rxsh_q == `UPM_ZERO8), ~rxline, rxsh_q};
                end
                default: rxst_q <= RX_IDLE;
            endcase
        end
    end

    // Receive RAM pointers and timeout counter
    always @(posedge i_ref_clk) begin
        if (i_srst | rxrst) begin
            rxwp_q           <= {(RXF_AW+1){1'b0}};
            rxrp_q           <= {(RXF_AW+1){1'b0}};
            o_rx_ram_wr_addr <= {RXF_AW{1'b0}};
            o_rx_ram_rd_addr <= {RXF_AW{1'b0}};
            o_rx_ram_rd_ce_n <= 1'b1;
            rx_push_q        <= 1'b0;
            to_q             <= 10'h000;
        end else begin
            rx_push_q <= rx_push;
            if (rx_push)
                rxwp_q <= rxwp_q + 1'b1;
            if (rx_pop)
                rxrp_q <= rxrp_q + 1'b1;
            o_rx_ram_wr_addr <= rx_push ? rxwp_q[RXF_AW-1:0] + 1'b1 : rxwp_q[RXF_AW-1:0];
            o_rx_ram_rd_addr <= rx_pop ? rxrp_q[RXF_AW-1:0] + 1'b1 : rxrp_q[RXF_AW-1:0];
            o_rx_ram_rd_ce_n <= rx_empty & ~rx_push;
            if (rx_push | rx_pop | rx_empty)
                to_q <= 10'h000;
            else if (tick & (to_q != `UPM_TO_TICKS))
                to_q <= to_q + 10'h001;
        end
    end

    // DMA, interrupt and sleep requests; all quiet out of reset
    wire tx_need = fen & fctl_q[`UPM_FC_DMA] ? (txf_lvl <= ({{(TXF_AW-1){1'b0}}, fctl_q[5:4]}
                   << (TXF_AW-3))) : ~txf_vld;
    wire rx_need = fen & fctl_q[`UPM_FC_DMA] ? s_rda | s_cto : ~rx_empty;
    wire tx_ack  = (EXTRA_DMA_SIGNALS_OPT_OPT != 0) & (i_dma_tx_ack == ACT);
    wire rx_ack  = (EXTRA_DMA_SIGNALS_OPT_OPT != 0) & (i_dma_rx_ack == ACT);
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            txhold_q         <= 1'b0;
            rxhold_q         <= 1'b0;
            o_dma_tx_req     <= ~ACT;
            o_dma_rx_req     <= ~ACT;
            o_dma_tx_single  <= ~ACT;
            o_dma_rx_single  <= ~ACT;
            o_legacy_tx_service_n      <= 1'b1;
            o_legacy_rx_service_n      <= 1'b1;
            o_interrupt_line           <= 1'b0;
            o_bus_domain_sleep_request <= 1'b0;
        end else begin
            // Acknowledge holds the request off until the need clears
            txhold_q <= tx_need & (txhold_q | tx_ack);
            rxhold_q <= rx_need & (rxhold_q | rx_ack);
            o_dma_tx_req <= (tx_need & ~txhold_q & ~tx_ack) ? ACT : ~ACT;
            o_dma_rx_req <= (rx_need & ~rxhold_q & ~rx_ack) ? ACT : ~ACT;
            o_dma_tx_single <= ((EXTRA_DMA_SIGNALS_OPT_OPT != 0) & ~txf_full) ? ACT : ~ACT;
            o_dma_rx_single <= ((EXTRA_DMA_SIGNALS_OPT_OPT != 0) & ~rx_empty) ? ACT : ~ACT;
            o_legacy_tx_service_n <= ~((EXTRA_DMA_SIGNALS_OPT_OPT == 0) & tx_need);
            o_legacy_rx_service_n <= ~((EXTRA_DMA_SIGNALS_OPT_OPT == 0) & rx_need);
            o_interrupt_line <= |act;
            o_bus_domain_sleep_request <= (CLK_GATE_EN != 0) & tx_idle & ~txf_vld
                & (rxst_q == RX_IDLE) & rx_empty & ~s_ms & ~i_scan_mode;
        end
    end
endmodule // upm_top

// ==== bench/upm_properties.sv ====
`timescale 1ns/10ps
// Watches the top ports; DMA levels follow the polarity option
module upm_properties #(parameter DMA_POLARITY_OPT_OPT = 1, EXTRA_DMA_SIGNALS_OPT_OPT = 1, RXF_AW = 5) (
    input wire logic              i_ref_clk, i_srst, i_psel, i_penable, i_pwrite,
    input wire logic [4:0]        i_paddr,
    input wire logic [31:0]       i_pwdata, o_prdata, o_diag_bus,
    input wire logic [RXF_AW-1:0] o_rx_ram_wr_addr,
    input wire logic              o_rx_ram_we_n, o_terminal_ready_out_n, o_request_send_out_n,
    input wire logic              o_dma_rx_req, o_dma_rx_single, o_legacy_tx_service_n,
    input wire logic              o_legacy_rx_service_n, o_serial_output, o_interrupt_line,
    input wire logic              o_bus_domain_sleep_request
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    localparam logic ACT = (DMA_POLARITY_OPT_OPT == 0);
    logic [RXF_AW-1:0] wa_inc;
    // Pointer wraps at the RAM depth, so compare in its own width
    assign wa_inc = o_rx_ram_wr_addr + 1'b1;
    wire mc_wr = i_psel && i_penable && i_pwrite && i_paddr[4:2] == 3'h4;
    AST_RST_QUIET: assert property ($past(i_srst) |-> !o_interrupt_line
        && o_dma_rx_req != ACT && !o_bus_domain_sleep_request) else $error("active after reset");
    AST_DIAG_ZERO: assert property (o_diag_bus[31:14] == 18'h0)
        else $error("diag upper bits set");
    AST_RDATA_BYTE: assert property (o_prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_LEGACY_IDLE: assert property (EXTRA_DMA_SIGNALS_OPT_OPT == 0 ||
        (o_legacy_tx_service_n && o_legacy_rx_service_n)) else $error("legacy service active");
    AST_MODEM_OUT: assert property (mc_wr |-> ##2
        o_terminal_ready_out_n == !$past(i_pwdata[0], 2)
        && o_request_send_out_n == !$past(i_pwdata[1], 2)) else $error("modem outputs wrong");
    AST_RAM_PTR: assert property (!o_rx_ram_we_n |=> o_rx_ram_wr_addr == $past(wa_inc))
        else $error("write pointer did not advance");
    AST_INTR_CAUSE: assert property ($rose(o_interrupt_line) |-> $past(|o_diag_bus[6:1]))
        else $error("interrupt without source");
    AST_DMA_SINGLE: assert property (o_dma_rx_req == ACT |-> o_dma_rx_single == ACT)
        else $error("receive request without entry");
    AST_BUSY_SLEEP: assert property (!o_serial_output [*2] |-> !o_bus_domain_sleep_request)
        else $error("sleep while sending");
    cover property (!o_rx_ram_we_n);
    cover property (o_dma_rx_req == ACT);
    cover property ($rose(o_interrupt_line));
endmodule // upm_properties
bind upm_top upm_properties #(.DMA_POLARITY_OPT_OPT(DMA_POLARITY_OPT_OPT), .EXTRA_DMA_SIGNALS_OPT_OPT(EXTRA_DMA_SIGNALS_OPT_OPT),
    .RXF_AW(RXF_AW)) upm_properties_i (.*);

// ==== bench/upm_partner.sv ====
`timescale 1ns/10ps
// Far side: echoing serial peer, external receive RAM, slow DMA controller
module upm_partner (
    input  wire logic       i_ref_clk, i_sout, i_we_n, i_tx_req, i_rx_req,
    input  wire logic [4:0] i_wa, i_ra,
    input  wire logic [9:0] i_wd,
    output logic            o_sin, o_tx_ack, o_rx_ack,
    output logic [9:0]      o_rd
);
    logic [9:0] mem [0:31];
    logic [1:0] txd = 2'h3, rxd = 2'h3;
    initial o_sin = 1'b1;
    // Peer echoes each bit one cycle later
    always @(posedge i_ref_clk) o_sin <= i_sout;
    // Receive RAM, read port without a clock
    always @(posedge i_ref_clk) if (!i_we_n) mem[i_wa] <= i_wd;
    assign o_rd = mem[i_ra];
    // Acks trail requests by two cycles, like a slow controller
    always @(posedge i_ref_clk) begin
        txd <= {txd[0], i_tx_req};
        rxd <= {rxd[0], i_rx_req};
    end
    assign o_tx_ack = txd[1];
    assign o_rx_ack = rxd[1];
endmodule // upm_partner

// ==== bench/tb_upm_top.sv ====
`timescale 1ns/10ps
module tb_upm_top;
    logic clk, srst, psel, pen, pwr, cts_n;
    logic [4:0] addr;
    logic [31:0] wd, rdv;
    wire [31:0] pr, dg;
    wire [9:0] rd, wdr;
    wire [4:0] ra, wa;
    wire we_n, sout, sin, txr, rxr, txa, rxa, tsn, rsn, u2n, u1n, intr, slp, txs;
    int failures = 0, total_checks = 0, n;
    upm_top upm_top_i (.i_ref_clk(clk), .i_srst(srst), .i_scan_mode(1'b0), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(pr),
        .i_rx_ram_out(rd), .o_rx_ram_in(wdr), .o_rx_ram_rd_addr(ra), .o_rx_ram_wr_addr(wa),
        .o_rx_ram_we_n(we_n), .o_rx_ram_re_n(), .o_rx_ram_rd_ce_n(), .i_clear_to_send_in_n(cts_n),
        .i_set_ready_in_n(1'b1), .i_carrier_detect_in_n(1'b1), .i_ring_indicate_in_n(1'b1),
        .o_terminal_ready_out_n(tsn), .o_request_send_out_n(rsn), .o_user_out_two_n(u2n),
        .o_user_out_one_n(u1n), .o_dma_tx_req(txr), .o_dma_tx_single(txs), .i_dma_tx_ack(txa),
        .o_dma_rx_req(rxr), .o_dma_rx_single(), .i_dma_rx_ack(rxa), .o_legacy_tx_service_n(),
        .o_legacy_rx_service_n(), .i_serial_input(sin), .o_serial_output(sout), .i_sir_in(1'b0),
        .o_sir_out_n(), .o_interrupt_line(intr), .o_diag_bus(dg), .o_bus_domain_sleep_request(slp));
    upm_partner upm_partner_i (.i_ref_clk(clk), .i_sout(sout), .i_we_n(we_n), .i_tx_req(txr),
        .i_rx_req(rxr), .i_wa(wa), .i_ra(ra), .i_wd(wdr), .o_sin(sin), .o_tx_ack(txa),
        .o_rx_ack(rxa), .o_rd(rd));
    task automatic chk(string s, logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    // One register transfer: setup, access, release; read data taken in access
    task automatic apb(logic w, logic [4:0] a, logic [7:0] d);
        @(negedge clk) {psel, pen, pwr, addr, wd} = {2'b10, w, a, 24'h0, d};
        @(negedge clk) pen = 1'b1;
        rdv = pr;
        @(negedge clk) {psel, pen} = 2'b00;
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {srst, psel, pen, pwr, addr, wd, cts_n} = {1'b1, 40'h0, 1'b1};
        repeat (8) @(negedge clk);
        srst = 1'b0;
        apb(0, 5'h04, 0); chk("ien_rst", rdv, 0);
        chk("sleep", slp, 1);
        chk("tx_single", txs, 0);
        $display("test reset done");
        apb(1, 5'h0C, 8'h80); apb(1, 5'h00, 8'h01); apb(1, 5'h04, 8'hA5);
        apb(0, 5'h00, 0); chk("div_lo", rdv, 1);
        apb(0, 5'h07, 0); chk("div_hi", rdv, 8'hA5);
        apb(1, 5'h04, 0); apb(1, 5'h0C, 8'h03); apb(1, 5'h05, 8'h0F);
        apb(0, 5'h04, 0); chk("ien", rdv, 8'h0F);
        apb(1, 5'h10, 8'h05); apb(1, 5'h08, 8'h01); chk("fifo_en", dg[0], 1);
        chk("modem", {tsn, rsn, u1n, u2n}, 4'b0101);
        $display("test registers done");
        // Back-to-back characters go out and return through the receive RAM
        for (n = 0; n < 3; n++) apb(1, 5'h00, 8'h5A + n);
        for (int k = 0; k < 1000 && wa !== 5'h03; k++) @(negedge clk);
        chk("rx_ptr", wa, 3);
        if (wa !== 5'h03) conclude;
        chk("intr", intr, 1);
        for (n = 0; n < 3; n++) begin
            apb(0, 5'h00, 0); chk("rx_data", rdv, 8'h5A + n);
        end
        $display("test echo done");
        cts_n = 1'b0;
        repeat (4) @(negedge clk);
        apb(0, 5'h18, 0); chk("modem_stat", rdv, 8'h11);
        $display("test modem done");
        conclude;
    end
endmodule // tb_upm_top
